// ---- core/alt_select.sv ----
// Alternating two-thread selector used at every pipeline selection point
`default_nettype none
module alt_select
  import smt_arb_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [1:0] want,
  output logic      [1:0] grant
);
  typedef struct packed {
    logic last;
  } sel_state_t;

  sel_state_t st_r;
  sel_state_t st_nxt;

  // ==========================================================================
  // Grant: alternate when both want, otherwise the lone requester takes it
  always_comb begin
    st_nxt = st_r;
    grant  = 2'h0;
    if (want == 2'h3) begin
      grant[~st_r.last] = 1'b1;
      st_nxt.last       = ~st_r.last;
    end else if (want[0]) begin
      grant[0]    = 1'b1;
      st_nxt.last = 1'b0;
    end else if (want[1]) begin
      grant[1]    = 1'b1;
      st_nxt.last = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r.last <= SEL_LAST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- core/smt_arb_pkg.sv ----
// Shared constants and types for the two-thread pipeline arbiter
`default_nettype none
package smt_arb_pkg;
  // ==========================================================================
  // Thread and selection points
  localparam int NTHR      = 2;
  localparam int NSEL      = 4;
  localparam int SEL_FETCH = 0;
  localparam int SEL_UOPQ  = 1;
  localparam int SEL_RET   = 2;
  localparam int SEL_STORE = 3;
  // Thread 1 marked as last winner so thread 0 is favoured after reset
  localparam logic SEL_LAST_RST = 1'b1;

  // ==========================================================================
  // Partitioned staging buffers
  localparam int NBUF      = 5;
  localparam int BUF_UOPQ  = 0;
  localparam int BUF_RENQ  = 1;
  localparam int BUF_ROB   = 2;
  localparam int BUF_LOAD  = 3;
  localparam int BUF_STORE = 4;
  localparam int CNT_W     = 7;
  localparam logic [CNT_W-1:0] UOPQ_DEPTH  = 7'h20;
  localparam logic [CNT_W-1:0] RENQ_DEPTH  = 7'h20;
  localparam logic [CNT_W-1:0] ROB_DEPTH   = 7'h40;
  localparam logic [CNT_W-1:0] LOAD_DEPTH  = 7'h20;
  localparam logic [CNT_W-1:0] STORE_DEPTH = 7'h18;

  // ==========================================================================
  // Execution dispatch
  localparam int WAITQ     = 16;
  localparam int DISP_MAX  = 6;

  // ==========================================================================
  // Translation buffer and per-thread state
  localparam int TLB_N     = 8;
  localparam int TLB_IW    = 3;
  localparam int NGPR      = 8;
  localparam int GPR_IW    = 3;
  localparam int RS_DEPTH  = 4;
  localparam int RS_PW     = 2;
  localparam logic [1:0] ISB_DEPTH = 2'h2;
  localparam logic [31:0] IP_RST   = 32'h0000_0000;
  localparam int DATA_W    = 32;

  typedef logic [DATA_W-1:0] word_t;
endpackage
`default_nettype wire

// ---- core/two_thread_pipeline_arbiter.sv ----
// Resource sharing and thread selection for a two-thread out-of-order pipeline
`default_nettype none
module two_thread_pipeline_arbiter
  import smt_arb_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic [1:0]                  thread_active,
  input  wire logic [1:0]                  fetch_req,
  input  wire logic [1:0]                  fetch_miss,
  input  wire logic [1:0]                  l2_fetch_return,
  input  wire logic [1:0]                  uopq_ready,
  input  wire logic [1:0]                  retire_ready,
  input  wire logic [1:0]                  store_commit_req,
  input  wire logic [NBUF-1:0][1:0]        alloc_req,
  input  wire logic [NBUF-1:0][1:0]        buf_free,
  input  wire logic [WAITQ-1:0]            waitq_ready,
  input  wire logic                        tlb_fill,
  input  wire logic [TLB_IW-1:0]           tlb_fill_idx,
  input  wire logic                        tlb_fill_thread,
  input  wire logic [TLB_IW-1:0]           tlb_look_idx,
  input  wire logic                        tlb_look_thread,
  input  wire logic                        ip_load,
  input  wire logic                        ip_thread,
  input  wire word_t                       ip_value,
  input  wire logic                        call_push,
  input  wire logic                        ret_pop,
  input  wire logic                        rs_thread,
  input  wire word_t                       call_addr,
  input  wire logic                        isb_push,
  input  wire logic                        isb_pop,
  input  wire logic                        isb_thread,
  input  wire logic                        gpr_we,
  input  wire logic                        gpr_thread,
  input  wire logic [GPR_IW-1:0]           gpr_widx,
  input  wire word_t                       gpr_wdata,
  input  wire logic [GPR_IW-1:0]           gpr_ridx,
  output logic      [1:0]                  fetch_grant,
  output logic      [1:0]                  uopq_grant,
  output logic      [1:0]                  retire_grant,
  output logic      [1:0]                  store_commit_grant,
  output logic      [NBUF-1:0][1:0]        alloc_ok,
  output logic      [WAITQ-1:0]            dispatch_grant,
  output logic                             tlb_owned,
  output word_t     [1:0]                  ip,
  output word_t                            ret_predict,
  output logic      [1:0]                  isb_full,
  output word_t                            gpr_rdata
);
  typedef struct packed {
    logic [1:0]                        fetch_pend;
    logic [1:0]                        fetch_grant;
    logic [1:0]                        uopq_grant;
    logic [1:0]                        retire_grant;
    logic [1:0]                        store_grant;
    logic [NBUF-1:0][1:0][CNT_W-1:0]   occ;
    logic [NBUF-1:0][1:0]              alloc_ok;
    logic [WAITQ-1:0]                  disp;
    logic [TLB_N-1:0]                  tlb_owner;
    logic                              tlb_owned;
    logic [1:0][DATA_W-1:0]            ip;
    logic [1:0][RS_DEPTH-1:0][DATA_W-1:0] rstack;
    logic [1:0][RS_PW-1:0]             rs_ptr;
    logic [DATA_W-1:0]                 ret_pred;
    logic [1:0][1:0]                   isb_cnt;
    logic [1:0]                        isb_full;
    logic [1:0][NGPR-1:0][DATA_W-1:0]  gpr;
    logic [DATA_W-1:0]                 gpr_rd;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ==========================================================================
  // Helpers
  function automatic logic [CNT_W-1:0] buf_depth(input int b);
    unique case (b)
      BUF_UOPQ: buf_depth = UOPQ_DEPTH;
      BUF_RENQ: buf_depth = RENQ_DEPTH;
      BUF_ROB:  buf_depth = ROB_DEPTH;
      BUF_LOAD: buf_depth = LOAD_DEPTH;
      default:  buf_depth = STORE_DEPTH;
    endcase
  endfunction

  // Per-thread ceiling; only the micro-op queue opens up when one thread runs alone
  function automatic logic [CNT_W-1:0] buf_limit(input int b, input logic both);
    if (b == BUF_UOPQ && !both) begin
      buf_limit = buf_depth(b);
    end else begin
      buf_limit = buf_depth(b) >> 1;
    end
  endfunction

  // Lowest-index ready entries win; thread of origin is not an input here
  function automatic logic [WAITQ-1:0] pick_ready(input logic [WAITQ-1:0] rdy);
    int n;
    pick_ready = '0;
    n = 0;
    for (int i = 0; i < WAITQ; i++) begin
      if (rdy[i] && n < DISP_MAX) begin
        pick_ready[i] = 1'b1;
        n++;
      end
    end
  endfunction

  // ==========================================================================
  // Selection points
  logic [NSEL-1:0][1:0] sel_want;
  logic [NSEL-1:0][1:0] sel_grant;

  always_comb begin
    sel_want            = '0;
    sel_want[SEL_FETCH] = fetch_req & ~st_r.fetch_pend;
    sel_want[SEL_UOPQ]  = uopq_ready;
    sel_want[SEL_RET]   = retire_ready;
    sel_want[SEL_STORE] = store_commit_req;
  end

  // One alternating selector per selection point
  for (genvar s = 0; s < NSEL; s++) begin : g_sel
    alt_select u_sel (
      .sys_clk (sys_clk),
      .reset   (reset),
      .want    (sel_want[s]),
      .grant   (sel_grant[s])
    );
  end

  // ==========================================================================
  // Next state
  always_comb begin
    logic            both;
    logic            take;
    logic [RS_PW-1:0] p;
    st_nxt = st_r;
    both   = &thread_active;
    take   = 1'b0;
    p      = '0;

    st_nxt.fetch_grant  = sel_grant[SEL_FETCH];
    st_nxt.uopq_grant   = sel_grant[SEL_UOPQ];
    st_nxt.retire_grant = sel_grant[SEL_RET];
    st_nxt.store_grant  = sel_grant[SEL_STORE];

    for (int t = 0; t < NTHR; t++) begin
      // Miss set wins over a return in the same cycle
      if (fetch_miss[t]) begin
        st_nxt.fetch_pend[t] = 1'b1;
      end else if (l2_fetch_return[t]) begin
        st_nxt.fetch_pend[t] = 1'b0;
      end
    end

    // Occupancy per buffer and thread; load/store ordering stays per thread
    for (int b = 0; b < NBUF; b++) begin
      for (int t = 0; t < NTHR; t++) begin
        take = alloc_req[b][t] && (st_r.occ[b][t] < buf_limit(b, both));
        st_nxt.alloc_ok[b][t] = take;
        if (take && !(buf_free[b][t] && st_r.occ[b][t] != '0)) begin
          st_nxt.occ[b][t] = st_r.occ[b][t] + 7'h01;
        end else if (!take && buf_free[b][t] && st_r.occ[b][t] != '0) begin
          st_nxt.occ[b][t] = st_r.occ[b][t] - 7'h01;
        end
      end
    end

    // Shared execution ports, no per-thread reservation
    st_nxt.disp = pick_ready(waitq_ready);

    if (tlb_fill) begin
      st_nxt.tlb_owner[tlb_fill_idx] = tlb_fill_thread;
    end
    st_nxt.tlb_owned = (st_r.tlb_owner[tlb_look_idx] == tlb_look_thread);

    if (ip_load) begin
      st_nxt.ip[ip_thread] = ip_value;
    end

    // Return stack wraps on overflow, losing the oldest entry by design
    p = st_r.rs_ptr[rs_thread];
    if (call_push) begin
      st_nxt.rstack[rs_thread][p] = call_addr;
      st_nxt.rs_ptr[rs_thread]    = p + 2'h1;
      st_nxt.ret_pred             = call_addr;
    end else if (ret_pop) begin
      st_nxt.ret_pred          = st_r.rstack[rs_thread][p - 2'h1];
      st_nxt.rs_ptr[rs_thread] = p - 2'h1;
    end

    // Streaming buffer per thread; push when full and pop when empty are dropped
    if (isb_push && !isb_pop && st_r.isb_cnt[isb_thread] != ISB_DEPTH) begin
      st_nxt.isb_cnt[isb_thread] = st_r.isb_cnt[isb_thread] + 2'h1;
    end else if (isb_pop && !isb_push && st_r.isb_cnt[isb_thread] != 2'h0) begin
      st_nxt.isb_cnt[isb_thread] = st_r.isb_cnt[isb_thread] - 2'h1;
    end
    for (int t = 0; t < NTHR; t++) begin
      st_nxt.isb_full[t] = (st_nxt.isb_cnt[t] == ISB_DEPTH);
    end

    // Range and monitoring registers live elsewhere as one shared copy
    if (gpr_we) begin
      st_nxt.gpr[gpr_thread][gpr_widx] = gpr_wdata;
    end
    st_nxt.gpr_rd = st_r.gpr[gpr_thread][gpr_ridx];
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign fetch_grant        = st_r.fetch_grant;
  assign uopq_grant         = st_r.uopq_grant;
  assign retire_grant       = st_r.retire_grant;
  assign store_commit_grant = st_r.store_grant;
  assign alloc_ok           = st_r.alloc_ok;
  assign dispatch_grant     = st_r.disp;
  assign tlb_owned          = st_r.tlb_owned;
  assign ip                 = st_r.ip;
  assign ret_predict        = st_r.ret_pred;
  assign isb_full           = st_r.isb_full;
  assign gpr_rdata          = st_r.gpr_rd;
endmodule
`default_nettype wire

// ---- dv/pipe_arb_checker.sv ----
// Checker: selector and dispatch relations on the arbiter's ports
`default_nettype none
module pipe_arb_checker
  import smt_arb_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             reset,
  input wire logic [1:0]       fetch_req,
  input wire logic [1:0]       fetch_miss,
  input wire logic [1:0]       l2_fetch_return,
  input wire logic [1:0]       fetch_grant,
  input wire logic [1:0]       uopq_ready,
  input wire logic [1:0]       uopq_grant,
  input wire logic [1:0]       retire_ready,
  input wire logic [1:0]       retire_grant,
  input wire logic [1:0]       store_commit_req,
  input wire logic [1:0]       store_commit_grant,
  input wire logic [WAITQ-1:0] waitq_ready,
  input wire logic [WAITQ-1:0] dispatch_grant
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Assertions
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence uq_both_s;
    (uopq_ready == 2'h3) ##1 (uopq_ready == 2'h3);
  endsequence
  // Miss held off by no return for two samples, so pending must be set
  sequence miss_s;
    (fetch_miss[0] && !l2_fetch_return[0]) ##1 !l2_fetch_return[0];
  endsequence
  retire_alt_a: assert property (retire_ready == 2'h3 && retire_grant == 2'h1
    |=> retire_grant == 2'h2) else $error("retire did not alternate");
  retire_alone_a: assert property (retire_ready == 2'h1 |=> retire_grant == 2'h1)
    else $error("lone retire requester not served");
  store_alt_a: assert property (store_commit_req == 2'h3 && store_commit_grant == 2'h2
    |=> store_commit_grant == 2'h1) else $error("store commit did not alternate");
  uopq_alt_a: assert property (uq_both_s |=> uopq_grant != $past(uopq_grant))
    else $error("uop queue grant repeated while both request");
  fetch_idle_a: assert property (fetch_req == 2'h0 |=> fetch_grant == 2'h0)
    else $error("fetch grant without request");
  fetch_miss_a: assert property (miss_s |=> !fetch_grant[0])
    else $error("fetch granted to a thread awaiting its fetch return");
  disp_max_a: assert property ($countones(dispatch_grant) <= DISP_MAX)
    else $error("too many dispatches in one cycle");
  disp_ready_a: assert property ((dispatch_grant & ~$past(waitq_ready)) == '0)
    else $error("dispatch of an entry that was not ready");
  disp_low_a: assert property (waitq_ready == '1 |=> dispatch_grant == 16'h003F)
    else $error("dispatch did not pick lowest ready entries");
endmodule
bind two_thread_pipeline_arbiter pipe_arb_checker u_chk (.sys_clk, .reset, .fetch_req,
  .fetch_miss, .l2_fetch_return, .fetch_grant, .uopq_ready, .uopq_grant, .retire_ready,
  .retire_grant, .store_commit_req, .store_commit_grant, .waitq_ready, .dispatch_grant);
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the two-thread pipeline arbiter
`default_nettype none
module testbench import smt_arb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals
  logic sys_clk, reset, tlb_fill, tlb_fill_thread, tlb_look_thread, ip_load, ip_thread;
  logic call_push, ret_pop, rs_thread, isb_push, isb_pop, isb_thread, gpr_we, gpr_thread;
  logic [1:0] thread_active, fetch_req, fetch_miss, l2_fetch_return, uopq_ready;
  logic [1:0] retire_ready, store_commit_req, fetch_grant, uopq_grant, retire_grant;
  logic [1:0] store_commit_grant, isb_full;
  logic [NBUF-1:0][1:0] alloc_req, buf_free, alloc_ok;
  logic [WAITQ-1:0] waitq_ready, dispatch_grant;
  logic [TLB_IW-1:0] tlb_fill_idx, tlb_look_idx;
  logic [GPR_IW-1:0] gpr_widx, gpr_ridx;
  logic tlb_owned;
  word_t ip_value, call_addr, gpr_wdata, ret_predict, gpr_rdata;
  word_t [1:0] ip;
  int err_total = 0;
  int n_compared = 0;

  two_thread_pipeline_arbiter u_dut (.sys_clk, .reset, .thread_active, .fetch_req,
    .fetch_miss, .l2_fetch_return, .uopq_ready, .retire_ready, .store_commit_req,
    .alloc_req, .buf_free, .waitq_ready, .tlb_fill, .tlb_fill_idx, .tlb_fill_thread,
    .tlb_look_idx, .tlb_look_thread, .ip_load, .ip_thread, .ip_value, .call_push, .ret_pop,
    .rs_thread, .call_addr, .isb_push, .isb_pop, .isb_thread, .gpr_we, .gpr_thread,
    .gpr_widx, .gpr_wdata, .gpr_ridx, .fetch_grant, .uopq_grant, .retire_grant,
    .store_commit_grant, .alloc_ok, .dispatch_grant, .tlb_owned, .ip, .ret_predict,
    .isb_full, .gpr_rdata);

  // ==========================================================================
  // Shared tasks
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_fetch();
    logic [1:0] ex [7] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2, 2'h1};
    fetch_req = 2'h3;
    for (int i = 0; i < 7; i++) begin
      @(negedge sys_clk);
      chk("fetch_grant", 32'(ex[i]), 32'(fetch_grant));
      fetch_miss = (i == 1) ? 2'h1 : 2'h0;
      l2_fetch_return = (i == 4) ? 2'h1 : 2'h0;
    end
    fetch_req = 2'h0;
    $display("test fetch done");
  endtask

  task automatic t_select();
    logic [1:0] rq [7] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h3, 2'h2, 2'h0};
    logic [1:0] ex [7] = '{2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
    for (int i = 0; i < 7; i++) begin
      {uopq_ready, retire_ready, store_commit_req} = {3{rq[i]}};
      @(negedge sys_clk);
      chk("uopq_grant", 32'(ex[i]), 32'(uopq_grant));
      chk("retire_grant", 32'(ex[i]), 32'(retire_grant));
      chk("store_commit_grant", 32'(ex[i]), 32'(store_commit_grant));
    end
    $display("test select done");
  endtask

  task automatic t_buf();
    int cnt [NBUF][2];
    logic [CNT_W-1:0] dp [NBUF] = '{UOPQ_DEPTH, RENQ_DEPTH, ROB_DEPTH, LOAD_DEPTH, STORE_DEPTH};
    alloc_req = '1;
    // Forty requests outrun every half-depth limit
    repeat (40) begin
      @(negedge sys_clk);
      for (int b = 0; b < NBUF; b++)
        for (int t = 0; t < 2; t++)
          cnt[b][t] += int'(alloc_ok[b][t]);
    end
    for (int b = 0; b < NBUF; b++)
      for (int t = 0; t < 2; t++)
        chk("alloc count", 32'(dp[b] >> 1), cnt[b][t]);
    alloc_req = '0;
    buf_free = '1;
    @(negedge sys_clk);
    buf_free = '0;
    alloc_req = '1;
    // Acceptance stands for one cycle only, so look right after the edge
    @(negedge sys_clk);
    chk("alloc after free", 32'h3FF, 32'(alloc_ok));
    thread_active = 2'h1;
    alloc_req = 10'h001;
    cnt[0][0] = 0;
    repeat (20) begin
      @(negedge sys_clk);
      cnt[0][0] += int'(alloc_ok[0][0]);
    end
    chk("uopq single count", 32'(UOPQ_DEPTH >> 1), cnt[0][0]);
    alloc_req = '0;
    thread_active = 2'h3;
    $display("test buffers done");
  endtask

  task automatic t_disp();
    logic [WAITQ-1:0] rq [3] = '{16'hFFFF, 16'h8421, 16'h0000};
    logic [WAITQ-1:0] ex [3] = '{16'h003F, 16'h8421, 16'h0000};
    for (int i = 0; i < 3; i++) begin
      waitq_ready = rq[i];
      @(negedge sys_clk);
      chk("dispatch_grant", 32'(ex[i]), 32'(dispatch_grant));
    end
    $display("test dispatch done");
  endtask

  task automatic t_tlb();
    {tlb_fill, tlb_fill_idx, tlb_fill_thread} = {1'h1, 3'h5, 1'h1};
    {tlb_look_idx, tlb_look_thread} = {3'h5, 1'h1};
    @(negedge sys_clk);
    tlb_fill = 1'h0;
    @(negedge sys_clk);
    chk("tlb_owned", 32'h1, 32'(tlb_owned));
    tlb_look_thread = 1'h0;
    @(negedge sys_clk);
    chk("tlb_owned", 32'h0, 32'(tlb_owned));
    $display("test tlb done");
  endtask

  task automatic t_state();
    {gpr_we, gpr_thread, gpr_widx, gpr_wdata} = {2'h2, 3'h3, 32'h1111_0000};
    {ip_load, ip_thread, ip_value} = {2'h3, 32'h0000_1000};
    {call_push, isb_push, isb_thread, call_addr} = {3'h7, 32'h0000_ABCD};
    @(negedge sys_clk);
    {gpr_thread, gpr_wdata, ip_load, call_push, ret_pop} = {1'h1, 32'h2222_0000, 3'h1};
    @(negedge sys_clk);
    {gpr_we, gpr_thread, gpr_ridx, ret_pop, isb_push} = {2'h0, 3'h3, 2'h0};
    @(negedge sys_clk);
    chk("gpr_rdata", 32'h1111_0000, gpr_rdata);
    chk("ip1", 32'h0000_1000, ip[1]);
    chk("ip0", IP_RST, ip[0]);
    chk("ret_predict", 32'h0000_ABCD, ret_predict);
    chk("isb_full", 32'h2, 32'(isb_full));
    gpr_thread = 1'h1;
    @(negedge sys_clk);
    chk("gpr_rdata", 32'h2222_0000, gpr_rdata);
    $display("test state done");
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (500) @(posedge sys_clk);
    err_total++;
    wrap_up();
  end

  initial begin
    reset = 1'h1;
    thread_active = 2'h3;
    {tlb_fill, tlb_fill_thread, tlb_look_thread, ip_load, ip_thread, call_push, ret_pop,
     rs_thread, isb_push, isb_pop, isb_thread, gpr_we, gpr_thread, fetch_req, fetch_miss,
     l2_fetch_return, uopq_ready, retire_ready, store_commit_req, alloc_req, buf_free,
     waitq_ready, tlb_fill_idx, tlb_look_idx, gpr_widx, gpr_ridx, ip_value, call_addr,
     gpr_wdata} = '0;
    repeat (12) @(negedge sys_clk);
    reset = 1'h0;
    t_fetch();
    t_select();
    t_buf();
    t_disp();
    t_tlb();
    t_state();
    wrap_up();
  end
endmodule
`default_nettype wire
